// ==== design/qrb_ctrl.sv ====
`timescale 1ns/10ps
`include "qrb_defs.svh"
module qrb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `QRB_FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_clock_en,
  // fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic [$clog2(DEPTH):0] o_count
);
  localparam int PW = $clog2(DEPTH);
  // pointers wrap by overflow, so DEPTH must be a power of two
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  wire push;
  wire pop;

  assign o_in_ready = count != (PW+1)'(DEPTH);
  assign o_out_valid = count != '0;
  assign push = i_clock_en & i_in_valid & o_in_ready;
  assign pop = i_clock_en & i_out_ready & o_out_valid;
  assign o_out_data = mem[rd_ptr];
  assign o_count = count;

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= wr_ptr + PW'(push);
      rd_ptr <= rd_ptr + PW'(pop);
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

module qrb_ctrl #(
  parameter int DATA_W = `QRB_DATA_W,
  parameter int ADDR_W = `QRB_ADDR_W,
  parameter int FIFO_DEPTH = `QRB_FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_clock_en,
  // command
  input wire logic i_cmd_valid,
  input wire logic i_cmd_write,
  input wire logic [ADDR_W-1:0] i_cmd_addr,
  output logic o_cmd_ready,
  // write data
  input wire logic i_wr_valid,
  input wire logic [DATA_W-1:0] i_wr_data,
  input wire logic [DATA_W/`QRB_BYTE_W-1:0] i_wr_byte_write_select_n,
  output logic o_wr_ready,
  // read data
  output logic o_rd_valid,
  output logic [DATA_W-1:0] o_rd_data,
  // link clock parking
  input wire logic i_clock_stop,
  output logic o_parked,
  // link to the memory
  qrb_link_if.ctrl link
);
  localparam int BYTES = DATA_W / `QRB_BYTE_W;
  localparam int FW = DATA_W + BYTES;
  localparam int CW = $clog2(FIFO_DEPTH) + 1;
  localparam int RC = `QRB_RD_CAPT0_CYCLE;
  localparam int WB = `QRB_WR_BEAT0_STEP - 1;

  qrb_pkg::qrb_link_t state;
  logic k;
  logic k_n;
  logic rsel_n;
  logic wsel_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] d;
  logic [BYTES-1:0] lane_n;
  logic [RC+3:0] rd_sh;
  logic [WB+3:0] wr_sh;
  logic rd_valid;
  logic [DATA_W-1:0] rd_data;

  wire [FW-1:0] fifo_out;
  wire [CW-1:0] fifo_count;
  wire fifo_pop;
  wire rise_next;
  wire rd_free;
  wire wr_free;
  wire issue_rd;
  wire issue_wr;
  wire park_now;
  wire [CW-1:0] wr_need;

  // a write is issued only when all four beats are already buffered
  assign wr_need = wr_sh[WB + 2] ? CW'(`QRB_WR_NEED_OVERLAP) : CW'(`QRB_WR_NEED);
  assign rise_next = (state == qrb_pkg::QRB_LINK_RUN) & ~k & ~i_clock_stop;
  assign rd_free = ~rd_sh[1]; // [R5]
  assign wr_free = ~wr_sh[1] & (fifo_count >= wr_need); // [R5]
  assign o_cmd_ready = rise_next & (i_cmd_write ? wr_free : rd_free);
  assign issue_rd = i_clock_en & i_cmd_valid & o_cmd_ready & ~i_cmd_write;
  assign issue_wr = i_clock_en & i_cmd_valid & o_cmd_ready & i_cmd_write;
  // a beat leaves the buffer one step before the device samples it
  assign fifo_pop = |wr_sh[WB+3:WB]; // [R1]
  assign park_now = i_clock_stop & k & ~(|rd_sh) & ~(|wr_sh);

  qrb_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) i_qrb_fifo (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_clock_en(i_clock_en),
    .i_in_valid(i_wr_valid),
    .o_in_ready(o_wr_ready),
    .i_in_data({i_wr_byte_write_select_n, i_wr_data}),
    .o_out_valid(),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_out),
    .o_count(fifo_count)
  );

  // link clock: toggles while running, parks with both phases high
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= qrb_pkg::QRB_LINK_PARK;
      k <= 1'b1;
      k_n <= 1'b1;
    end else if (i_clock_en) begin
      unique case (state)
        qrb_pkg::QRB_LINK_RUN: begin
          if (park_now) begin
            state <= qrb_pkg::QRB_LINK_PARK;
            k_n <= 1'b1; // [R8]
          end else begin
            k <= ~k;
            k_n <= k;
          end
        end
        qrb_pkg::QRB_LINK_PARK: begin
          if (!i_clock_stop) begin
            state <= qrb_pkg::QRB_LINK_RUN;
            k <= 1'b0;
          end
        end
      endcase
    end
  end

  // selects, address, schedules, write beats
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rsel_n <= 1'b1;
      wsel_n <= 1'b1;
      addr <= '0;
      d <= '0;
      lane_n <= '1;
      rd_sh <= '0;
      wr_sh <= '0;
    end else if (i_clock_en) begin
      rsel_n <= ~issue_rd;
      wsel_n <= ~issue_wr; // [R1]
      if (issue_rd || issue_wr) begin
        addr <= i_cmd_addr;
      end
      rd_sh <= {rd_sh[RC+2:0], issue_rd};
      wr_sh <= {wr_sh[WB+2:0], issue_wr};
      if (fifo_pop) begin
        d <= fifo_out[DATA_W-1:0];
        lane_n <= fifo_out[FW-1:DATA_W]; // [R13]
      end
    end
  end

  // read capture in the four cycles the device drives its beats
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else if (i_clock_en) begin
      rd_valid <= |rd_sh[RC+3:RC]; // [R2]
      rd_data <= link.q;
    end
  end

  assign link.k = k;
  assign link.k_n = k_n;
  assign link.read_port_select_n = rsel_n;
  assign link.write_port_select_n = wsel_n;
  assign link.addr = addr;
  assign link.d = d;
  assign link.byte_write_select_n = lane_n;
  assign o_rd_valid = rd_valid;
  assign o_rd_data = rd_data;
  assign o_parked = state == qrb_pkg::QRB_LINK_PARK;
endmodule

// ==== design/qrb_sram_port.sv ====
`timescale 1ns/10ps
`include "qrb_defs.svh"
module qrb_sram_port #(
  parameter int DATA_W = `QRB_DATA_W,
  parameter int ADDR_W = `QRB_ADDR_W
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_clock_en,
  // link to the controller
  qrb_link_if.device link,
  // status
  output logic o_read_busy,
  output logic o_write_busy,
  output logic o_read_ignored,
  output logic o_write_ignored,
  output qrb_pkg::qrb_op_t o_last_start
);
  localparam int BYTES = DATA_W / `QRB_BYTE_W;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int RD_LO = `QRB_RD_LOAD0_STEP - 1;
  localparam int RD_HI = RD_LO + `QRB_BURST_LEN - 1;
  localparam int WR_LO = `QRB_WR_BEAT0_STEP - 1;
  localparam int WR_HI = WR_LO + `QRB_BURST_LEN - 1;

  // previous clock levels; the link phases are plain logic on this clock
  logic k_q;
  logic k_n_q;

  // starts seen at the previous positive rise
  logic prev_rd;
  logic prev_wr;

  // one bit per burst in flight, shifted once per link step
  logic [RD_HI:0] rd_sh;
  logic [WR_HI:0] wr_sh;

  // burst base addresses; base is taken at start, cur once the burst is under way
  logic [ADDR_W-1:0] rd_base;
  logic [ADDR_W-1:0] rd_cur;
  logic [ADDR_W-1:0] wr_base;
  logic [ADDR_W-1:0] wr_cur;

  logic q_oe;
  logic read_ignored;
  logic write_ignored;
  qrb_pkg::qrb_op_t last_start;

  wire k_rise;
  wire kn_rise;
  wire step;
  wire rd_sel;
  wire wr_sel;
  wire rd_req;
  wire wr_req;
  wire rd_start;
  wire wr_start;
  wire rd_beat_en;
  wire wr_beat_en;
  wire [1:0] rd_beat;
  wire [1:0] wr_beat;
  wire [ADDR_W-1:0] rd_addr;
  wire [ADDR_W-1:0] wr_addr;
  wire [DATA_W-1:0] q_word;

  // a parked link (both phases high) makes no rise, so every pipe freezes
  assign k_rise = link.k & ~k_q; // [R4]
  assign kn_rise = link.k_n & ~k_n_q; // [R4]
  assign step = i_clock_en & (k_rise | kn_rise); // [R7]

  assign rd_sel = ~link.read_port_select_n;
  assign wr_sel = ~link.write_port_select_n;

  // a select that started something last rise is not looked at this rise
  assign rd_req = rd_sel & ~prev_rd; // [R6] [R5]
  assign wr_req = wr_sel & ~prev_wr; // [R6] [R5]

  // read wins a tie only when it was free to go; this yields read, write, read...
  assign rd_start = i_clock_en & k_rise & rd_req; // [R2] [R15]
  assign wr_start = i_clock_en & k_rise & wr_req & ~rd_req; // [R1] [R15]

  // with starts at least two rises apart, at most one burst sits in each window
  assign rd_beat_en = step & (|rd_sh[RD_HI:RD_LO]);
  assign wr_beat_en = step & (|wr_sh[WR_HI:WR_LO]); // [R14]

  assign rd_beat = rd_sh[RD_LO + 3] ? 2'h3 :
                   rd_sh[RD_LO + 2] ? 2'h2 :
                   rd_sh[RD_LO + 1] ? 2'h1 : 2'h0;
  assign wr_beat = wr_sh[WR_LO + 3] ? 2'h3 :
                   wr_sh[WR_LO + 2] ? 2'h2 :
                   wr_sh[WR_LO + 1] ? 2'h1 : 2'h0;

  // beat 0 reads base directly: a new start may overwrite base on that very step
  assign rd_addr = rd_sh[RD_LO] ? rd_base : rd_cur + ADDR_W'(rd_beat); // [R3]
  assign wr_addr = wr_sh[WR_LO] ? wr_base : wr_cur + ADDR_W'(wr_beat); // [R3]

  // link edge tracking
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      k_q <= 1'b1;
      k_n_q <= 1'b1;
    end else if (i_clock_en) begin
      k_q <= link.k;
      k_n_q <= link.k_n;
    end
  end

  // start bookkeeping, sampled on positive rises only
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prev_rd <= 1'b0; // [R9]
      prev_wr <= 1'b0; // [R9]
    end else if (i_clock_en && k_rise) begin
      prev_rd <= rd_start;
      prev_wr <= wr_start;
    end
  end

  // deselecting only stops new starts; queued beats run out on the link steps that follow
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_sh <= '0;
      wr_sh <= '0;
    end else if (step) begin
      rd_sh <= {rd_sh[RD_HI-1:0], rd_start}; // [R16] [R2]
      wr_sh <= {wr_sh[WR_HI-1:0], wr_start}; // [R16] [R1]
    end
  end

  // address capture
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_base <= '0;
      rd_cur <= '0;
      wr_base <= '0;
      wr_cur <= '0;
    end else if (step) begin
      if (rd_start) begin
        rd_base <= link.addr;
      end
      if (rd_sh[RD_LO]) begin
        rd_cur <= rd_base;
      end
      if (wr_start) begin
        wr_base <= link.addr;
      end
      if (wr_sh[WR_LO]) begin
        wr_cur <= wr_base;
      end
    end
  end

  // read outputs are driven only while a burst is on them
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q_oe <= 1'b0; // [R9]
    end else if (step) begin
      q_oe <= |rd_sh[RD_HI:RD_LO]; // [R14] [R2]
    end
  end

  // per-lane storage: a lane whose select is high keeps its old contents
  for (genvar g = 0; g < BYTES; g++) begin : g_lane
    logic [`QRB_BYTE_W-1:0] mem [DEPTH];
    logic [`QRB_BYTE_W-1:0] q_lane;
    wire lane_we;

    assign lane_we = wr_beat_en & ~link.byte_write_select_n[g]; // [R10] [R11] [R12] [R13]

    always_ff @(posedge i_clock) begin
      if (lane_we) begin
        mem[wr_addr] <= link.d[g*`QRB_BYTE_W +: `QRB_BYTE_W]; // [R4]
      end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
        q_lane <= '0;
      end else if (rd_beat_en) begin
        q_lane <= mem[rd_addr]; // [R4] [R7]
      end
    end

    assign q_word[g*`QRB_BYTE_W +: `QRB_BYTE_W] = q_lane;
  end

  assign link.q = q_word;
  assign link.q_oe = q_oe;

  // status: refused second starts and the operation started at the latest positive rise (idle if none)
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      read_ignored <= 1'b0;
      write_ignored <= 1'b0;
      last_start <= qrb_pkg::QRB_OP_IDLE;
    end else if (i_clock_en) begin
      read_ignored <= k_rise & rd_sel & prev_rd; // [R5]
      write_ignored <= k_rise & wr_sel & prev_wr; // [R5]
      if (rd_start) begin
        last_start <= qrb_pkg::QRB_OP_READ;
      end else if (wr_start) begin
        last_start <= qrb_pkg::QRB_OP_WRITE;
      end else if (k_rise) begin
        last_start <= qrb_pkg::QRB_OP_IDLE;
      end
    end
  end

  assign o_read_busy = (|rd_sh) | q_oe;
  assign o_write_busy = |wr_sh;
  assign o_read_ignored = read_ignored;
  assign o_write_ignored = write_ignored;
  assign o_last_start = last_start;
endmodule

// ==== dv/qrb_link_chk.sv ====
`timescale 1ns/10ps
module qrb_link_chk #(
  parameter int DATA_W = 18
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // link
  input wire logic k,
  input wire logic k_n,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic [DATA_W-1:0] q,
  input wire logic q_oe
);
  logic k_q;
  logic rd_last;
  logic wr_last;
  wire logic krise = k & ~k_q;
  // read wins a tie unless it went at the previous rise
  wire logic rd_go = krise & ~read_port_select_n & ~rd_last;
  wire logic wr_go = krise & ~write_port_select_n & ~wr_last & ~rd_go;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      k_q <= 1'b1;
      rd_last <= 1'b0;
      wr_last <= 1'b0;
    end else begin
      k_q <= k;
      if (krise) begin
        rd_last <= rd_go;
        wr_last <= wr_go;
      end
    end
  end

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  sequence read_beats;
    q_oe [*4];
  endsequence
  sequence both_high;
    k && k_n;
  endsequence

  rd_window_a: assert property (rd_go |-> ##5 read_beats)
    else $error("read burst not driven for four steps");
  oe_cause_a: assert property ($rose(q_oe) |-> $past(rd_go, 5))
    else $error("read output enabled without a read start");
  oe_end_a: assert property ($fell(q_oe) |-> $past(rd_go, 9))
    else $error("read output released early or late");
  park_high_a: assert property (k == k_n |-> k)
    else $error("link clocks equal but not parked high");
  park_hold_a: assert property (both_high ##1 both_high |-> $stable(q) && $stable(q_oe))
    else $error("read side moved while clocks stopped");
  rd_space_a: assert property (krise && !read_port_select_n |-> !rd_last)
    else $error("reads issued on consecutive rises");
  wr_space_a: assert property (krise && !write_port_select_n |-> !wr_last)
    else $error("writes issued on consecutive rises");
  quiet_start_a: assert property ($rose(i_arst_n) |-> !q_oe ##1 !q_oe)
    else $error("read output driven after reset");
endmodule

// ==== dv/quad_rate_burst_sram_port_tb.sv ====
`timescale 1ns/10ps
module quad_rate_burst_sram_port_tb;
  logic i_clock, i_arst_n, en, cmd_valid, cmd_write, wr_valid, stop;
  logic cmd_ready, wr_ready, rd_valid, parked, rign2, wign2, rbusy2, wbusy2;
  logic [9:0] cmd_addr;
  logic [17:0] wr_data, rd_data;
  logic [17:0] mem [0:1023];
  logic [1:0] wr_lane_n;
  logic [15:0] seed = 16'hb3fa;
  logic [19:0] wq [$];
  logic [17:0] exp_q [$];
  logic [5:0] tab [7] = '{6'h04, 6'h0a, 6'h05, 6'h12, 6'h30, 6'h28, 6'h21};
  int mismatches = 0;
  int n_checks = 0;
  qrb_pkg::qrb_op_t last2;
  qrb_link_if link ();
  qrb_link_if link2 ();

  qrb_ctrl i_qrb_ctrl (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_clock_en(en),
    .i_cmd_valid(cmd_valid), .i_cmd_write(cmd_write), .i_cmd_addr(cmd_addr),
    .o_cmd_ready(cmd_ready), .i_wr_valid(wr_valid), .i_wr_data(wr_data),
    .i_wr_byte_write_select_n(wr_lane_n), .o_wr_ready(wr_ready), .o_rd_valid(rd_valid),
    .o_rd_data(rd_data), .i_clock_stop(stop), .o_parked(parked), .link(link.ctrl));
  qrb_sram_port i_qrb_sram_port (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_clock_en(en), .link(link.device), .o_read_busy(), .o_write_busy(),
    .o_read_ignored(), .o_write_ignored(), .o_last_start());
  // second device faces the bench directly so the link rules can be broken
  qrb_sram_port i_qrb_sram_port_2 (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_clock_en(en), .link(link2.device), .o_read_busy(rbusy2), .o_write_busy(wbusy2),
    .o_read_ignored(rign2), .o_write_ignored(wign2), .o_last_start(last2));
  qrb_link_chk #(.DATA_W(18)) i_qrb_link_chk (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .k(link.k), .k_n(link.k_n), .read_port_select_n(link.read_port_select_n),
    .write_port_select_n(link.write_port_select_n), .q(link.q), .q_oe(link.q_oe));

  initial begin
    i_clock = 0;
    forever #2 i_clock = ~i_clock;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk_data(input string n, input logic [17:0] e, input logic [17:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_flag(input string n, input logic [1:0] e, input logic [1:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic push(input logic [17:0] w, input logic [1:0] m);
    @(negedge i_clock);
    wr_valid = 1;
    wr_data = w;
    wr_lane_n = m;
    while (wr_ready !== 1'b1) @(negedge i_clock);
    wq.push_back({m, w});
    @(negedge i_clock);
    wr_valid = 0;
  endtask

  // the model memory is updated when the command is handed over
  task automatic cmd(input logic w, input logic [9:0] a);
    logic [19:0] e;
    logic [9:0] ad;
    @(negedge i_clock);
    cmd_valid = 1;
    cmd_write = w;
    cmd_addr = a;
    // ready depends on the kind of command, so let it settle before looking
    #1;
    while (cmd_ready !== 1'b1) begin
      @(negedge i_clock);
      #1;
    end
    @(negedge i_clock);
    cmd_valid = 0;
    for (int n = 0; n < 4; n++) begin
      ad = a + n[9:0];
      if (w) begin
        e = wq.pop_front();
        for (int g = 0; g < 2; g++) begin
          if (!e[18+g]) mem[ad][9*g +: 9] = e[9*g +: 9];
        end
      end else begin
        exp_q.push_back(mem[ad]);
      end
    end
  endtask

  task automatic kick(input logic [5:0] t);
    @(negedge i_clock);
    seed = lfsr(seed);
    link2.k = 1;
    link2.k_n = 0;
    link2.read_port_select_n = t[5];
    link2.write_port_select_n = t[4];
    link2.addr = seed[9:0];
    link2.d = {seed[1:0], seed};
    @(negedge i_clock);
    link2.k = 0;
    link2.k_n = 1;
    link2.read_port_select_n = 1;
    link2.write_port_select_n = 1;
    chk_flag("last_start", t[3:2], last2);
    chk_flag("ignored", t[1:0], {rign2, wign2});
  endtask

  always @(negedge i_clock) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("[FAIL] rd_data expected none seen %h", rd_data);
      end else begin
        chk_data("rd_data", exp_q.pop_front(), rd_data);
      end
    end
  end

  initial begin
    repeat (6000) @(posedge i_clock);
    mismatches++;
    close_out();
  end

  initial begin
    {en, cmd_valid, cmd_write, wr_valid, stop} = 5'h10;
    cmd_addr = 10'h000;
    wr_data = 18'h00000;
    wr_lane_n = 2'h3;
    link2.k = 1;
    link2.k_n = 1;
    link2.read_port_select_n = 1;
    link2.write_port_select_n = 1;
    link2.addr = 10'h000;
    link2.d = 18'h00000;
    link2.byte_write_select_n = 2'h3;
    i_arst_n = 0;
    repeat (20) @(posedge i_clock);
    @(negedge i_clock);
    i_arst_n = 1;
    // first pass writes whole words, second pass random lane masks
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 8; i++) begin
        seed = lfsr(seed);
        push({seed[15:14], seed}, p == 0 ? 2'h0 : (i == 3 ? 2'h3 : seed[5:4]));
      end
      @(negedge i_clock);
      chk_flag("wr_ready", 2'h0, {1'b0, wr_ready});
      if (p == 1) begin
        stop = 1;
        while (parked !== 1'b1) @(negedge i_clock);
        repeat (6) @(negedge i_clock);
        chk_flag("parked", 2'h1, {1'b0, parked});
        // with the enable low a lifted stop request must not wake the link
        en = 1'b0;
        stop = 1'b0;
        repeat (3) @(negedge i_clock);
        chk_flag("frozen", 2'h1, {1'b0, parked});
        en = 1'b1;
      end
      cmd(1, 10'h3fc);
      cmd(1, 10'h000);
      repeat (12) @(negedge i_clock);
      cmd(0, 10'h3fc);
      cmd(0, 10'h000);
      while (exp_q.size() != 0) @(negedge i_clock);
    end
    @(negedge i_clock);
    link2.k = 0;
    link2.k_n = 1;
    for (int i = 0; i < 7; i++) kick(tab[i]);
    repeat (12) @(negedge i_clock);
    // link stopped mid write: the write stays pending, the reads have run out
    chk_flag("busy", 2'h1, {rbusy2, wbusy2});
    close_out();
  end
endmodule

// ==== include/qrb_defs.svh ====
`ifndef QRB_DEFS_SVH
`define QRB_DEFS_SVH
// Overview of operation
// [R1] write: read select high, write select low
// [R2] read data leaves 2.5 cycles after start
// [R3] burst covers four consecutive word addresses
// [R4] data moves on both input clock rises
// [R5] same operation on consecutive rises is ignored
// [R6] select used last rise is don't-care now
// [R7] stopped clocks hold all data state
// [R8] controller parks both clocks high when stopped
// [R9] power-up deselected, read outputs not driven
// [R10] narrow width: two low-active lane selects
// [R11] wide width: four low-active lane selects
// [R12] all lane selects high writes nothing
// [R13] lane selects may change every beat
// [R14] idle cycle ignores data, outputs undriven
// [R15] both selects low: alternate, read first
// [R16] deselect never aborts pending bursts

// lane and burst shape
`define QRB_BYTE_W 9
`define QRB_BURST_LEN 4
`define QRB_DATA_W 18
`define QRB_ADDR_W 10

// link steps counted from the start rise (one step per clock rise of either phase)
`define QRB_WR_BEAT0_STEP 2
`define QRB_RD_LOAD0_STEP 4
`define QRB_RD_CAPT0_CYCLE 5

// controller side buffering
`define QRB_FIFO_DEPTH 8
`define QRB_WR_NEED 4
`define QRB_WR_NEED_OVERLAP 6

// clock
`define QRB_CLK_PERIOD_NS 4
`endif

// ==== include/qrb_link_if.sv ====
`timescale 1ns/10ps
`include "qrb_defs.svh"
interface qrb_link_if #(
  parameter int DATA_W = `QRB_DATA_W,
  parameter int ADDR_W = `QRB_ADDR_W
) ();
  localparam int BYTES = DATA_W / `QRB_BYTE_W;
  logic k;
  logic k_n;
  logic read_port_select_n;
  logic write_port_select_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] d;
  logic [BYTES-1:0] byte_write_select_n;
  logic [DATA_W-1:0] q;
  logic q_oe;

  modport device (
    input k, k_n, read_port_select_n, write_port_select_n, addr, d, byte_write_select_n,
    output q, q_oe
  );
  modport ctrl (
    output k, k_n, read_port_select_n, write_port_select_n, addr, d, byte_write_select_n,
    input q, q_oe
  );
endinterface

// ==== include/qrb_pkg.sv ====
package qrb_pkg;
  typedef enum logic [1:0] {
    QRB_OP_IDLE  = 2'b00,
    QRB_OP_READ  = 2'b01,
    QRB_OP_WRITE = 2'b10
  } qrb_op_t;

  typedef enum logic {
    QRB_LINK_RUN  = 1'b0,
    QRB_LINK_PARK = 1'b1
  } qrb_link_t;
endpackage
